// ### sis_i2c_slave.v
/*
 Two-wire slave register port: framing, address match, pointer,
 buffered writes, fetched reads, clock stretching.
 Assumes open-drain pins resolved outside, a register file on mclk
 behind the write buffer and read request, and any SPI engine outside.
*/
// How it works
// - Match address b110100X, X taken from the strap level after reset.
// - SDA falling while SCL high is START; it restarts the receive state.
// - Bus is busy from START to STOP; repeated START keeps it busy.
// - Bytes are eight bits plus an acknowledge slot, any number per transfer.
// - Receiver pulls SDA low through the high phase of the ninth clock.
// - Hold SCL low while a byte cannot yet be stored or fetched.
// - SDA changes only while SCL is low, outside START and STOP.
// - Write: header with direction 0, pointer byte, data; each acknowledged.
// - Further write bytes go to successive registers, pointer plus one each.
// - Read: write pointer, repeated START, read header acknowledged, then data.
// - Master NACK on ninth clock ends a read; device releases SDA.
// - Repeated START with a foreign address sends the port back to idle.
// - Disable input keeps the port from engaging, for SPI users.
// - Strap, clock and data pins double as SPI lines outside this block.
// - Registers are also reachable by an SPI port up to 8 MHz, outside.
`include "sis_i2c_map.vh"

module sis_i2c_slave (
    input wire mclk,
    input wire rstn,
    input wire sclIn,
    output wire sclOut,
    output wire sclOeN,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOeN,
    input wire lsbSelectPin,
    input wire twoWirePortDisable,
    output wire wrValid,
    input wire wrReady,
    output wire [7:0] wrAddr,
    output wire [7:0] wrData,
    output reg rdReq,
    output reg [7:0] rdAddr,
    input wire rdValid,
    input wire [7:0] rdData,
    output reg busBusy,
    output reg addressed
);
    localparam ST_IDLE = 7'h01;
    localparam ST_RECV = 7'h02;
    localparam ST_ACK = 7'h04;
    localparam ST_FETCH = 7'h08;
    localparam ST_SEND = 7'h10;
    localparam ST_MACK = 7'h20;
    localparam ST_PUSH = 7'h40;

    // Header byte matches our address
    function addrMatch;
        input [7:0] header;
        input lsb;
        begin
            addrMatch = (header[7:1] == {`SIS_ADDR_HI, lsb});
        end
    endfunction

    // Pointer advance, wrapping at the top
    function [7:0] nextPtr;
        input [7:0] ptr;
        begin
            nextPtr = ptr + 8'h01;
        end
    endfunction

    wire [2:0] pinSync;
    wire scl;
    wire sda;
    wire strapSync;
    reg sclPrev;
    reg sdaPrev;
    wire sclRise;
    wire sclFall;
    wire startSeen;
    wire stopSeen;

    reg [6:0] state;
    reg [3:0] bitCnt;
    reg [7:0] shiftReg;
    reg [7:0] pointer;
    reg [1:0] byteRole;
    reg readMode;
    reg masterAck;
    reg sdaDrive;
    reg sclHold;
    reg fetchIssued;
    reg [1:0] strapWait;
    reg strapLsb;

    wire byteDone;
    wire pushValid;
    wire pushReady;
    wire [15:0] pushData;
    wire [15:0] popData;

    // Pin levels into the mclk domain
    sis_sync2 u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din({lsbSelectPin, sdaIn, sclIn}),
        .dout(pinSync)
    );

    assign scl = pinSync[0];
    assign sda = pinSync[1];
    assign strapSync = pinSync[2];

    // Edge history of the synchronised lines
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sda;
        end
    end

    // Line events; sampling margin holds below 400 kHz
    assign sclRise = scl && !sclPrev;
    assign sclFall = !scl && sclPrev;
    assign startSeen = sdaPrev && !sda && scl && sclPrev;
    assign stopSeen = !sdaPrev && sda && scl && sclPrev;

    // Strap taken once, a few cycles after reset release
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strapWait <= 2'h0;
            strapLsb <= 1'b0;
        end else if (strapWait != `SIS_STRAP_WAIT) begin
            strapWait <= strapWait + 2'h1;
            strapLsb <= strapSync;
        end
    end

    // Bus busy flag, independent of our address
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busBusy <= 1'b0;
        end else if (startSeen) begin
            busBusy <= 1'b1;
        end else if (stopSeen) begin
            busBusy <= 1'b0;
        end
    end

    // Full byte received, seen on the falling edge after bit eight
    assign byteDone = (state == ST_RECV) && sclFall && (bitCnt == `SIS_BYTE_BITS);

    // Write words enter the buffer as pointer and data
    assign pushValid = ((byteDone && (byteRole == `SIS_ROLE_DATA)) || (state == ST_PUSH))
                       && !startSeen && !stopSeen;
    assign pushData = {pointer, shiftReg};

    sis_buf2 u_buf (
        .mclk(mclk),
        .rstn(rstn),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushData),
        .outValid(wrValid),
        .outReady(wrReady),
        .outData(popData)
    );

    assign wrAddr = popData[15:8];
    assign wrData = popData[7:0];

    // Open-drain pins: only ever pull low
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;
    assign sdaOeN = ~sdaDrive;
    assign sclOeN = ~sclHold;

    // Transfer engine
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            pointer <= `SIS_PTR_RESET;
            byteRole <= `SIS_ROLE_ADDR;
            readMode <= 1'b0;
            masterAck <= 1'b0;
            sdaDrive <= 1'b0;
            sclHold <= 1'b0;
            fetchIssued <= 1'b0;
            rdReq <= 1'b0;
            rdAddr <= 8'h00;
            addressed <= 1'b0;
        end else begin
            rdReq <= 1'b0;
            if (twoWirePortDisable) begin
                // Port never engages while disabled
                state <= ST_IDLE;
                sdaDrive <= 1'b0;
                sclHold <= 1'b0;
                fetchIssued <= 1'b0;
                addressed <= 1'b0;
            end else if (startSeen) begin
                // START or repeated START: fresh header expected
                state <= ST_RECV;
                bitCnt <= 4'h0;
                byteRole <= `SIS_ROLE_ADDR;
                sdaDrive <= 1'b0;
                sclHold <= 1'b0;
                fetchIssued <= 1'b0;
                addressed <= 1'b0;
            end else if (stopSeen) begin
                state <= ST_IDLE;
                sdaDrive <= 1'b0;
                sclHold <= 1'b0;
                fetchIssued <= 1'b0;
                addressed <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        // Lines released until the next START
                        sdaDrive <= 1'b0;
                        sclHold <= 1'b0;
                    end
                    ST_RECV: begin
                        if (sclRise && bitCnt != `SIS_BYTE_BITS) begin
                            // Sample on the high phase, MSB first
                            shiftReg <= {shiftReg[6:0], sda};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (byteDone) begin
                            case (byteRole)
                                `SIS_ROLE_ADDR: begin
                                    if (addrMatch(shiftReg, strapLsb)) begin
                                        readMode <= shiftReg[0];
                                        addressed <= 1'b1;
                                        sdaDrive <= 1'b1;
                                        byteRole <= `SIS_ROLE_PTR;
                                        state <= ST_ACK;
                                    end else begin
                                        state <= ST_IDLE;
                                    end
                                end
                                `SIS_ROLE_PTR: begin
                                    pointer <= shiftReg;
                                    sdaDrive <= 1'b1;
                                    byteRole <= `SIS_ROLE_DATA;
                                    state <= ST_ACK;
                                end
                                default: begin
                                    if (pushReady) begin
                                        pointer <= nextPtr(pointer);
                                        sdaDrive <= 1'b1;
                                        state <= ST_ACK;
                                    end else begin
                                        sclHold <= 1'b1;
                                        state <= ST_PUSH;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_PUSH: begin
                        // SCL held low until the buffer takes the byte
                        if (pushReady) begin
                            pointer <= nextPtr(pointer);
                            sdaDrive <= 1'b1;
                            state <= ST_ACK;
                        end
                    end
                    ST_ACK: begin
                        // Acknowledge stands through the ninth high phase
                        sclHold <= 1'b0; // SDA settles a cycle before SCL is let go
                        if (sclFall) begin
                            sdaDrive <= 1'b0;
                            bitCnt <= 4'h0;
                            if (readMode) begin
                                sclHold <= 1'b1;
                                state <= ST_FETCH;
                            end else begin
                                state <= ST_RECV;
                            end
                        end
                    end
                    ST_FETCH: begin
                        // Ask for the byte once, stretch until it arrives
                        if (!fetchIssued) begin
                            rdReq <= 1'b1;
                            rdAddr <= pointer;
                            fetchIssued <= 1'b1;
                        end else if (rdValid) begin
                            shiftReg <= rdData;
                            sdaDrive <= ~rdData[7];
                            bitCnt <= 4'h0;
                            fetchIssued <= 1'b0;
                            state <= ST_SEND;
                        end
                    end
                    ST_SEND: begin
                        // Next bit set up on each falling edge
                        sclHold <= 1'b0; // First bit already on SDA
                        if (sclFall) begin
                            bitCnt <= bitCnt + 4'h1;
                            if (bitCnt == `SIS_BYTE_BITS - 4'h1) begin
                                sdaDrive <= 1'b0;
                                state <= ST_MACK;
                            end else begin
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                sdaDrive <= ~shiftReg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        // Master answers in the ninth clock
                        if (sclRise) begin
                            masterAck <= ~sda;
                            pointer <= nextPtr(pointer);
                        end else if (sclFall) begin
                            if (masterAck) begin
                                sclHold <= 1'b1;
                                state <= ST_FETCH;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        sdaDrive <= 1'b0;
                        sclHold <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // sis_i2c_slave

// ### sis_i2c_map.vh
/*
 Constants shared by the two-wire slave port: address, byte framing,
 strap capture and buffer geometry. Assumes inclusion by bare name.
*/
`ifndef SIS_I2C_MAP_VH
`define SIS_I2C_MAP_VH

// Fixed upper six bits of the 7-bit slave address (b110100X)
`define SIS_ADDR_HI 6'h34
// Bits per byte and the count after which the byte is complete
`define SIS_BYTE_BITS 4'h8
// Byte roles inside one transfer
`define SIS_ROLE_ADDR 2'h0
`define SIS_ROLE_PTR 2'h1
`define SIS_ROLE_DATA 2'h2
// Reset value of the register pointer
`define SIS_PTR_RESET 8'h00
// Master serial clock ceiling, kHz, and SPI clock ceiling, kHz
`define SIS_SCL_MAX_KHZ 400
`define SIS_SPI_MAX_KHZ 8000
// Cycles after reset release before the strap level is taken
`define SIS_STRAP_WAIT 2'h3
// Width of one buffered write: pointer and data
`define SIS_WR_WIDTH 16

`endif

// ### sis_sync2.v
/*
 Two-flop synchroniser for three pin levels.
 Assumes each input is a level from outside the mclk domain.
*/
module sis_sync2 (
    input wire mclk,
    input wire rstn,
    input wire [2:0] din,
    output wire [2:0] dout
);
    reg [2:0] stage1;
    reg [2:0] stage2;

    // Idle-high bus lines reset high, strap resets low
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= 3'h3;
            stage2 <= 3'h3;
        end else begin
            stage1 <= din;
            stage2 <= stage1; // Only reader of stage1
        end
    end

    assign dout = stage2;
endmodule // sis_sync2

// ### sis_buf2.v
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes both sides on mclk; drain side may stall freely.
*/
module sis_buf2 (
    input wire mclk,
    input wire rstn,
    input wire inValid,
    output wire inReady,
    input wire [15:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [15:0] outData
);
    reg [15:0] mem [0:1];
    reg wrPtr;
    reg rdPtr;
    reg [1:0] count;
    wire doPush;
    wire doPop;

    // Honest full and empty
    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData = mem[rdPtr];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // Storage words
    always @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and fill level
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (doPush) begin
                wrPtr <= ~wrPtr;
            end
            if (doPop) begin
                rdPtr <= ~rdPtr;
            end
            if (doPush && !doPop) begin
                count <= count + 2'h1;
            end else if (doPop && !doPush) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule // sis_buf2

// ### sis_i2c_slave_assertions.sv
/*
 Assertion checker for the two-wire slave port.
 Assumes a bind to sis_i2c_slave; everything on mclk.
*/
module sis_i2c_slave_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sclIn,
    input wire logic sclOeN,
    input wire logic sdaIn,
    input wire logic sdaOeN,
    input wire logic twoWirePortDisable,
    input wire logic wrValid,
    input wire logic wrReady,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic rdReq,
    input wire logic [7:0] rdAddr,
    input wire logic rdValid,
    input wire logic busBusy,
    input wire logic addressed
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [7:0] prevRd;
    reg haveRd;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // Last fetch address of the current read
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prevRd <= 8'h00;
            haveRd <= 1'h0;
        end else if (rdReq) begin
            prevRd <= rdAddr;
            haveRd <= 1'h1;
        end else if (!addressed) begin
            haveRd <= 1'h0;
        end
    end
    // Start condition seen on the pins
    sequence startSeen;
        sclIn && $past(sclIn) && !sdaIn && $past(sdaIn);
    endsequence
    quiet_foreign_a: assert property (!addressed |-> sdaOeN && sclOeN)
        else $error("line pulled while unaddressed");
    busy_start_a: assert property (startSeen ##0 !twoWirePortDisable |-> ##[1:8] busBusy)
        else $error("busy not raised after start");
    free_stop_a: assert property (sclIn && $past(sclIn) && sdaIn && !$past(sdaIn) |-> ##[1:8] !busBusy)
        else $error("busy not dropped after stop");
    restart_drop_a: assert property (startSeen ##0 addressed |-> ##[1:8] !addressed)
        else $error("selection kept over restart");
    port_off_a: assert property (twoWirePortDisable [*4] |-> sdaOeN && sclOeN && !addressed)
        else $error("disabled port engaged");
    sda_low_a: assert property ($changed(sdaOeN) |-> !$past(sclIn))
        else $error("data changed with clock high");
    setup_first_a: assert property ($rose(sclOeN) && !twoWirePortDisable |-> $stable(sdaOeN))
        else $error("data changed as stretch ended");
    fetch_hold_a: assert property (rdReq |-> !sclOeN ##1 !rdReq)
        else $error("fetch without stretch");
    wait_data_a: assert property (rdReq ##1 !rdValid |-> !sclOeN)
        else $error("clock released before data");
    read_step_a: assert property (rdReq && haveRd |-> rdAddr == prevRd + 8'h01)
        else $error("read address not stepped");
    write_hold_a: assert property (wrValid && !wrReady |=> wrValid && $stable(wrAddr) && $stable(wrData))
        else $error("buffered word lost");
    cover property (wrValid && wrReady);
    cover property (rdReq);
    cover property (!sclOeN && !wrReady);
endmodule // sis_i2c_slave_checker

// ### sis_master_model.sv
/*
 Two-wire bus master model: start, stop, byte send and receive.
 Assumes open-drain lines resolved with pull-ups in the bench.
*/
module sis_master_model (
    input wire logic mclk,
    input wire logic sclW,
    input wire logic sdaW,
    output logic mSclOeN,
    output logic mSdaOeN,
    output logic rxStb,
    output logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ph = 1'h0;
    // Lines released, clock still outside frames
    initial begin
        mSclOeN = 1'h1;
        mSdaOeN = 1'h1;
        rxStb = 1'h0;
        rxByte = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One bit: 60 ns low, 60 or 70 ns high, 125 ns mean
    task automatic bitx(input logic b, output logic s);
        int n;
        tick(3);
        mSdaOeN = b;
        tick(3);
        mSclOeN = 1'h1;
        n = 0;
        while (!sclW && n < 3000) begin
            tick(1);
            n++;
        end
        ph = !ph;
        tick(3);
        s = sdaW;
        tick(3 + ph);
        mSclOeN = 1'h0;
    endtask
    task automatic start();
        tick(3);
        mSdaOeN = 1'h1;
        tick(3);
        mSclOeN = 1'h1;
        tick(6);
        mSdaOeN = 1'h0;
        tick(6);
        mSclOeN = 1'h0;
    endtask
    task automatic stop();
        tick(3);
        mSdaOeN = 1'h0;
        tick(3);
        mSclOeN = 1'h1;
        tick(6);
        mSdaOeN = 1'h1;
        tick(6);
    endtask
    // Eight bits MSB first, then SDA released for the ack
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'h1, s);
        ack = !s;
    endtask
    // Receive a byte, then ack or leave SDA high
    task automatic getByte(input logic ackIt);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'h1, s);
            rxByte[i] = s;
        end
        bitx(!ackIt, s);
        rxStb = 1'h1;
        tick(1);
        rxStb = 1'h0;
    endtask
endmodule // sis_master_model

// ### sis_i2c_slave_bench.sv
/*
 Self-checking bench for the two-wire slave port.
 Assumes the master model and a bench register file on mclk.
*/
module sis_i2c_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rstn, lsbSelectPin, twoWirePortDisable, wrReady, rdValid, ack;
    logic [7:0] rdData, d, fa;
    wire sclOut, sclOeN, sdaOut, sdaOeN, wrValid, rdReq, busBusy, addressed, mSclOeN, mSdaOeN, rxStb;
    wire [7:0] wrAddr, wrData, rdAddr, rxByte;
    wire sclW = (sclOeN | sclOut) & mSclOeN;
    wire sdaW = (sdaOeN | sdaOut) & mSdaOeN;
    logic [31:0] seed = 32'h632F81D4;
    int mismatches = 0;
    int comparisons = 0;
    logic [15:0] expWr[$];
    logic [7:0] expRd[$];
    logic stall = 1'h0;
    sis_i2c_slave sis_i2c_slave_inst (.mclk(mclk), .rstn(rstn), .sclIn(sclW), .sclOut(sclOut),
        .sclOeN(sclOeN), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .lsbSelectPin(lsbSelectPin),
        .twoWirePortDisable(twoWirePortDisable), .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr),
        .wrData(wrData), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData),
        .busBusy(busBusy), .addressed(addressed));
    sis_master_model sis_master_model_inst (.mclk(mclk), .sclW(sclW), .sdaW(sdaW), .mSclOeN(mSclOeN),
        .mSdaOeN(mSdaOeN), .rxStb(rxStb), .rxByte(rxByte));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] regVal(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction
    task automatic report(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkAck(input logic e, input logic g);
        report("ack", {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic chkWr(input logic [15:0] e, input logic [15:0] g);
        report("write word", e, g);
    endtask
    task automatic chkRd(input logic [7:0] e, input logic [7:0] g);
        report("read byte", {8'h00, e}, {8'h00, g});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic sb(input logic [7:0] v, input logic e);
        sis_master_model_inst.sendByte(v, ack);
        chkAck(e, ack);
    endtask
    task automatic doReset(input logic strap);
        @(posedge mclk);
        #1 rstn = 1'h0;
        lsbSelectPin = strap;
        repeat (3) @(posedge mclk);
        #1 rstn = 1'h1;
        repeat (8) @(posedge mclk);
        #1;
    endtask
    // Clock, 10 ns period
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // Register file take side: random stalls or a long hold
    always @(posedge mclk) begin
        #1 wrReady = stall ? 1'h0 : (rnd() % 4 != 0);
    end
    // Register file fetch side, slow by a random 1 to 4 cycles
    initial forever begin
        @(posedge mclk);
        #1;
        if (rdReq === 1'h1) begin
            fa = rdAddr;
            repeat (1 + rnd() % 4) @(posedge mclk);
            #1 rdValid = 1'h1;
            rdData = regVal(fa);
            @(posedge mclk);
            #1 rdValid = 1'h0;
            rdData = ~rdData;
        end
    end
    // Result watchers: oldest note against each result
    always @(posedge mclk) begin
        if (rstn && wrValid === 1'h1 && wrReady === 1'h1)
            chkWr(expWr.size() ? expWr.pop_front() : 16'hXXXX, {wrAddr, wrData});
        if (rxStb === 1'h1)
            chkRd(expRd.size() ? expRd.pop_front() : 8'hXX, rxByte);
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rstn = 1'h0;
        lsbSelectPin = 1'h0;
        twoWirePortDisable = 1'h0;
        wrReady = 1'h0;
        rdValid = 1'h0;
        rdData = 8'h00;
        doReset(1'h0);
        stall = 1'h1;
        fork
            begin
                repeat (800) @(posedge mclk);
                #1 stall = 1'h0;
            end
        join_none
        sis_master_model_inst.start();
        sb(8'hD0, 1'h1);
        sb(8'hFE, 1'h1);
        for (int i = 0; i < 4; i++) begin
            d = 8'(rnd());
            expWr.push_back({8'(8'hFE + i), d});
            sb(d, 1'h1);
        end
        sis_master_model_inst.stop();
        sis_master_model_inst.start();
        sb(8'hD0, 1'h1);
        sb(8'h10, 1'h1);
        sis_master_model_inst.start();
        sb(8'hD1, 1'h1);
        for (int i = 0; i < 3; i++) begin
            expRd.push_back(regVal(8'(8'h10 + i)));
            sis_master_model_inst.getByte(i < 2);
        end
        sis_master_model_inst.stop();
        sis_master_model_inst.start();
        sb(8'hD0, 1'h1);
        sis_master_model_inst.start();
        sb(8'hD4, 1'h0);
        sis_master_model_inst.stop();
        sis_master_model_inst.start();
        sb(8'hD2, 1'h0);
        sis_master_model_inst.stop();
        twoWirePortDisable = 1'h1;
        sis_master_model_inst.start();
        sb(8'hD0, 1'h0);
        sis_master_model_inst.stop();
        twoWirePortDisable = 1'h0;
        doReset(1'h1);
        sis_master_model_inst.start();
        sb(8'hD2, 1'h1);
        sb(8'h33, 1'h1);
        sis_master_model_inst.start();
        sb(8'hD3, 1'h1);
        expRd.push_back(regVal(8'h33));
        sis_master_model_inst.getByte(1'h0);
        sis_master_model_inst.stop();
        sis_master_model_inst.start();
        sb(8'hD0, 1'h0);
        sis_master_model_inst.stop();
        repeat (20) @(posedge mclk);
        report("pending notes", 16'h0000, 16'(expWr.size() + expRd.size()));
        give_verdict();
    end
endmodule // sis_i2c_slave_bench
bind sis_i2c_slave sis_i2c_slave_checker sis_i2c_slave_checker_inst (.mclk(mclk), .rstn(rstn),
    .sclIn(sclIn), .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOeN(sdaOeN), .twoWirePortDisable(twoWirePortDisable),
    .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData), .rdReq(rdReq),
    .rdAddr(rdAddr), .rdValid(rdValid), .busBusy(busBusy), .addressed(addressed));
